/* File: hw/hiad_top.sv */
// host interface auto-detect: reads straps after reset, locks mode, routes pins
// assumes pads outside resolve each pin from its _o/_oe pair; one clock, sync reset
//
// Contract
// - after every hard reset the interface logic restarts and finds the host type by itself.
// - the type is found by sampling strap and control pin levels once reset is over.
// - address straps all 0 with both strobes high select UART.
// - straps 000001 with strobes high select SPI; 00001x selects I2C with pin 0 as address mode.
// - in serial modes the latch pin and data pins 7..5 take the UART, SPI or I2C roles.
// - in I2C data pins 4..0 give slave address bits 2..6 and pins 6,5 give bits 0,1 gated by address mode, else unused.
`timescale 1ns/10ps
module hiad_top
  import hiad_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic addr_strobe_pin,
  input wire logic [5:0] addr_strap_pin,
  input wire logic read_strobe_n_pin,
  input wire logic write_strobe_n_pin,
  input wire logic [7:0] data_pin_i,
  input wire logic uart_tx_data,
  input wire logic uart_aux_out_data,
  input wire logic uart_request_data,
  input wire logic spi_miso_data,
  input wire logic spi_miso_en,
  output hiad_pkg::hiad_if_t if_type,
  output logic if_locked,
  output logic [7:0] data_pin_o,
  output logic [7:0] data_pin_oe,
  output logic serial_rx,
  output logic spi_nss,
  output logic spi_mosi,
  output logic spi_sck,
  output logic i2c_sda_in,
  output logic i2c_scl_in,
  output logic [6:0] i2c_slave_addr,
  output logic i2c_addr_mode
);
  import hiad_pkg::*;

  // pins are asynchronous: two flops before any logic
  logic [16:0] pin_raw;
  logic [16:0] pin_s;
  assign pin_raw = {addr_strobe_pin, read_strobe_n_pin, write_strobe_n_pin,
                    addr_strap_pin, data_pin_i};

  hiad_sync #(.WIDTH(17)) u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .async_in(pin_raw),
    .sync_out(pin_s)
  );

  wire latch_s = pin_s[16];
  wire rd_n_s = pin_s[15];
  wire wr_n_s = pin_s[14];
  wire [5:0] strap_s = pin_s[13:8];
  wire [7:0] data_s = pin_s[7:0];

  hiad_state_t state_reg, state_next;
  hiad_if_t type_reg, type_next;
  logic [HIAD_CNT_W-1:0] cnt_reg, cnt_next;
  logic mode_reg, mode_next;

  // decode of the strap pattern
  function automatic hiad_if_t decode_strap(input logic [5:0] s, input logic rd_n,
                                            input logic wr_n);
    hiad_if_t t;
    t = HIAD_IF_PAR_DED;
    if (rd_n && wr_n && s == HIAD_STRAP_UART) t = HIAD_IF_UART;
    else if (rd_n && wr_n && s == HIAD_STRAP_SPI) t = HIAD_IF_SPI;
    else if (rd_n && wr_n && (s & HIAD_STRAP_I2C_MASK) == HIAD_STRAP_I2C) t = HIAD_IF_I2C;
    else if ((s & HIAD_STRAP_MUX_MASK) == HIAD_STRAP_MUX)
      t = s[0] ? HIAD_IF_PAR_SEP : HIAD_IF_PAR_COM;
    return t;
  endfunction

  wire hiad_if_t strap_type = decode_strap(strap_s, rd_n_s, wr_n_s);
  wire settle_done = (cnt_reg == HIAD_SETTLE_LAST);

  always_comb begin
    state_next = state_reg;
    type_next = type_reg;
    cnt_next = cnt_reg;
    mode_next = mode_reg;
    unique case (state_reg)
      HIAD_ST_SETTLE: begin
        cnt_next = cnt_reg + 1'b1;
        if (settle_done) state_next = HIAD_ST_SAMPLE;
      end
      HIAD_ST_SAMPLE: begin
        type_next = strap_type;
        mode_next = strap_s[0];
        state_next = HIAD_ST_LOCKED;
      end
      HIAD_ST_LOCKED: begin
        state_next = HIAD_ST_LOCKED;
      end
      default: state_next = HIAD_ST_SETTLE;
    endcase
  end

  // reset restarts detection with no host action
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_reg <= HIAD_ST_SETTLE;
      type_reg <= HIAD_IF_NONE;
      cnt_reg <= '0;
      mode_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      type_reg <= type_next;
      cnt_reg <= cnt_next;
      mode_reg <= mode_next;
    end
  end

  wire is_uart = (type_reg == HIAD_IF_UART);
  wire is_spi = (type_reg == HIAD_IF_SPI);
  wire is_i2c = (type_reg == HIAD_IF_I2C);

  // pin roles; unused pins stay undriven
  logic [7:0] dout_next, doe_next;
  assign dout_next = is_uart ? {uart_tx_data, uart_aux_out_data, uart_request_data, 5'h00} :
                     is_spi ? {spi_miso_data, 7'h00} : 8'h00;
  assign doe_next = is_uart ? 8'hE0 : (is_spi && spi_miso_en) ? 8'h80 : 8'h00;
  // address bits 0,1 from data 6,5 and 2..6 from data 4..0, reversed order
  wire [6:0] adr_pins = {data_s[0], data_s[1], data_s[2], data_s[3], data_s[4],
                         data_s[5], data_s[6]};
  // without address mode the pin-set part is ignored; low bits stay programmable elsewhere
  wire [6:0] adr_next = !is_i2c ? HIAD_ADDR_RESET :
                        mode_reg ? adr_pins : {adr_pins[6:2], 2'h0};

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      data_pin_o <= 8'h00;
      data_pin_oe <= 8'h00;
      serial_rx <= 1'b1;
      spi_nss <= 1'b1;
      spi_mosi <= 1'b0;
      spi_sck <= 1'b0;
      i2c_sda_in <= 1'b1;
      i2c_scl_in <= 1'b1;
      i2c_slave_addr <= HIAD_ADDR_RESET;
      i2c_addr_mode <= 1'b0;
      if_type <= HIAD_IF_NONE;
      if_locked <= 1'b0;
    end else begin
      data_pin_o <= dout_next;
      data_pin_oe <= doe_next;
      serial_rx <= is_uart ? latch_s : 1'b1;
      spi_nss <= is_spi ? latch_s : 1'b1;
      spi_mosi <= is_spi & data_s[6];
      spi_sck <= is_spi & data_s[5];
      i2c_sda_in <= is_i2c ? latch_s : 1'b1;
      i2c_scl_in <= is_i2c ? data_s[7] : 1'b1;
      i2c_slave_addr <= adr_next;
      i2c_addr_mode <= is_i2c & mode_reg;
      if_type <= type_reg;
      if_locked <= (state_reg == HIAD_ST_LOCKED);
    end
  end

  // the locked type never changes while out of reset
  a_type_held: assert property (@(posedge sys_clk) disable iff (rst)
    state_reg == HIAD_ST_LOCKED |=> $stable(type_reg))
    else $error("locked type changed");
  a_out_held: assert property (@(posedge sys_clk) disable iff (rst)
    if_locked |=> if_locked && $stable(if_type))
    else $error("reported type moved after lock");
  a_settle_len: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(state_reg == HIAD_ST_SAMPLE) |-> $past(cnt_reg) == HIAD_SETTLE_LAST)
    else $error("sampled before settle time");
  a_reset_restart: assert property (@(posedge sys_clk)
    rst |=> state_reg == HIAD_ST_SETTLE && type_reg == HIAD_IF_NONE)
    else $error("reset did not restart detection");
  a_uart_pick: assert property (@(posedge sys_clk) disable iff (rst)
    state_reg == HIAD_ST_SAMPLE && strap_s == 6'h00 && rd_n_s && wr_n_s
    |=> type_reg == HIAD_IF_UART)
    else $error("uart straps not decoded");
  a_spi_pick: assert property (@(posedge sys_clk) disable iff (rst)
    state_reg == HIAD_ST_SAMPLE && strap_s == 6'h01 && rd_n_s && wr_n_s
    |=> type_reg == HIAD_IF_SPI)
    else $error("spi straps not decoded");
  a_i2c_pick: assert property (@(posedge sys_clk) disable iff (rst)
    state_reg == HIAD_ST_SAMPLE && strap_s[5:1] == 5'h01 && rd_n_s && wr_n_s
    |=> type_reg == HIAD_IF_I2C && mode_reg == $past(strap_s[0]))
    else $error("i2c straps not decoded");
  // straps may move after the sample; only the sampled copy counts
  a_mux_pick: assert property (@(posedge sys_clk) disable iff (rst)
    state_reg == HIAD_ST_SAMPLE && strap_s[5:1] == 5'h03
    |=> type_reg == ($past(strap_s[0]) ? HIAD_IF_PAR_SEP : HIAD_IF_PAR_COM))
    else $error("parallel straps not decoded");
  a_uart_pins: assert property (@(posedge sys_clk) disable iff (rst)
    is_uart |=> data_pin_oe == 8'hE0 && data_pin_o[7] == $past(uart_tx_data))
    else $error("uart pin roles wrong");
  a_low_unused: assert property (@(posedge sys_clk) disable iff (rst)
    !is_i2c |=> data_pin_oe[4:0] == 5'h00 && i2c_slave_addr == 7'h00)
    else $error("low data pins used outside i2c");
  a_spi_pins: assert property (@(posedge sys_clk) disable iff (rst)
    is_spi |=> spi_nss == $past(latch_s) && spi_mosi == $past(data_s[6])
    && spi_sck == $past(data_s[5]))
    else $error("spi input roles wrong");
  a_miso_drive: assert property (@(posedge sys_clk) disable iff (rst)
    is_spi |=> data_pin_oe == {$past(spi_miso_en), 7'h00}
    && data_pin_o[7] == $past(spi_miso_data))
    else $error("miso drive wrong");
  a_i2c_pins: assert property (@(posedge sys_clk) disable iff (rst)
    is_i2c |=> i2c_sda_in == $past(latch_s) && i2c_scl_in == $past(data_s[7])
    && data_pin_oe == 8'h00)
    else $error("i2c pin roles wrong");
  a_i2c_addr: assert property (@(posedge sys_clk) disable iff (rst)
    is_i2c |=> i2c_slave_addr[2] == $past(data_s[4])
    && i2c_slave_addr[6] == $past(data_s[0]) && i2c_addr_mode == $past(mode_reg)
    && i2c_slave_addr[0] == ($past(mode_reg) && $past(data_s[6])))
    else $error("i2c slave address wrong");

  c_uart: cover property (@(posedge sys_clk) disable iff (rst) if_locked && is_uart);
  c_spi: cover property (@(posedge sys_clk) disable iff (rst) if_locked && is_spi);
  c_i2c: cover property (@(posedge sys_clk) disable iff (rst) if_locked && is_i2c);
  c_par: cover property (@(posedge sys_clk) disable iff (rst)
    if_locked && type_reg == HIAD_IF_PAR_COM);
  c_par_sep: cover property (@(posedge sys_clk) disable iff (rst)
    if_locked && type_reg == HIAD_IF_PAR_SEP);
endmodule

/* File: hw/hiad_pkg.sv */
// package for the host interface auto-detect block
// assumes a single 40 MHz sys_clk domain and a synchronous active-high reset
package hiad_pkg;

  // detected interface types, held until the next hard reset
  typedef enum logic [2:0] {
    HIAD_IF_NONE     = 3'h0,
    HIAD_IF_UART     = 3'h1,
    HIAD_IF_SPI      = 3'h2,
    HIAD_IF_I2C      = 3'h3,
    HIAD_IF_PAR_SEP  = 3'h4,
    HIAD_IF_PAR_COM  = 3'h5,
    HIAD_IF_PAR_DED  = 3'h6
  } hiad_if_t;

  // detector sequencing
  typedef enum logic [1:0] {
    HIAD_ST_SETTLE = 2'h0,
    HIAD_ST_SAMPLE = 2'h1,
    HIAD_ST_LOCKED = 2'h2
  } hiad_state_t;

  // strap pattern on address pins 5..0
  localparam logic [5:0] HIAD_STRAP_UART = 6'h00;
  localparam logic [5:0] HIAD_STRAP_SPI = 6'h01;
  localparam logic [5:0] HIAD_STRAP_I2C_MASK = 6'h3E;
  localparam logic [5:0] HIAD_STRAP_I2C = 6'h02;
  localparam logic [5:0] HIAD_STRAP_MUX_MASK = 6'h3E;
  localparam logic [5:0] HIAD_STRAP_MUX = 6'h06;

  // settle time after reset release before the straps are read
  localparam int HIAD_CLK_HZ = 40000000;
  localparam int HIAD_SETTLE_NS = 1000;
  localparam int HIAD_SETTLE_CYC = (HIAD_SETTLE_NS * (HIAD_CLK_HZ / 1000000) + 999) / 1000;
  localparam int HIAD_CNT_W = 6;
  localparam logic [HIAD_CNT_W-1:0] HIAD_SETTLE_LAST = HIAD_CNT_W'(HIAD_SETTLE_CYC - 1);

  localparam logic [6:0] HIAD_ADDR_RESET = 7'h00;

endpackage

/* File: hw/hiad_sync.sv */
// two-flop synchroniser for a bundle of pin levels
// assumes inputs are asynchronous to sys_clk
`timescale 1ns/10ps
module hiad_sync #(
  parameter int WIDTH = 1
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;

  // first stage is read only by the second stage
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule

/* File: dv/hiad_host_model.sv */
// host board model: strap ties, latch pin and data pin levels
// assumes the bench picks the levels; pins change 1 ns after sys_clk rises
`timescale 1ns/10ps
module hiad_host_model (
  input wire logic sys_clk,
  input wire logic [5:0] strap_sel,
  input wire logic [7:0] data_sel,
  input wire logic latch_sel,
  output logic [5:0] addr_strap_pin,
  output logic read_strobe_n_pin,
  output logic write_strobe_n_pin,
  output logic addr_strobe_pin,
  output logic [7:0] data_pin_i
);
  initial begin
    addr_strap_pin = 6'h00;
    read_strobe_n_pin = 1'h1;
    write_strobe_n_pin = 1'h1;
    addr_strobe_pin = 1'h1;
    data_pin_i = 8'h00;
  end
  // board ties: strobes stay high so every serial pattern is legal
  always @(posedge sys_clk) begin
    addr_strap_pin <= #1 strap_sel;
    read_strobe_n_pin <= #1 1'h1;
    write_strobe_n_pin <= #1 1'h1;
    addr_strobe_pin <= #1 latch_sel;
    data_pin_i <= #1 data_sel;
  end
endmodule

/* File: dv/tb_host_interface_autodetect.sv */
// bench for hiad_top: strap table, i2c address, pin roles, lock hold
// assumes the host model drives all pin levels; 40 MHz sys_clk
`timescale 1ns/10ps
module tb_host_interface_autodetect;
  import hiad_pkg::*;
  logic sys_clk = 1'h0, rst = 1'h1, latch_sel = 1'h1, miso_d = 1'h0, miso_en = 1'h0;
  logic tx_d = 1'h1, aux_d = 1'h0, req_d = 1'h0;
  logic [5:0] strap_sel = 6'h00, strap;
  logic [7:0] data_sel = 8'h00, d_i, d_o, d_oe;
  logic as_p, rd_n, wr_n, locked, rx, nss, mosi, sck, sda, scl, ea;
  logic [6:0] i2c_addr;
  hiad_if_t if_type;
  int n_errors = 0, checks = 0;
  initial forever #12.5 sys_clk = ~sys_clk;
  hiad_host_model host_u (.sys_clk(sys_clk), .strap_sel(strap_sel), .data_sel(data_sel),
    .latch_sel(latch_sel), .addr_strap_pin(strap), .read_strobe_n_pin(rd_n),
    .write_strobe_n_pin(wr_n), .addr_strobe_pin(as_p), .data_pin_i(d_i));
  hiad_top dut_u (.sys_clk(sys_clk), .rst(rst), .addr_strobe_pin(as_p), .addr_strap_pin(strap),
    .read_strobe_n_pin(rd_n), .write_strobe_n_pin(wr_n), .data_pin_i(d_i),
    .uart_tx_data(tx_d), .uart_aux_out_data(aux_d), .uart_request_data(req_d),
    .spi_miso_data(miso_d), .spi_miso_en(miso_en), .if_type(if_type), .if_locked(locked),
    .data_pin_o(d_o), .data_pin_oe(d_oe), .serial_rx(rx), .spi_nss(nss), .spi_mosi(mosi),
    .spi_sck(sck), .i2c_sda_in(sda), .i2c_scl_in(scl), .i2c_slave_addr(i2c_addr),
    .i2c_addr_mode(ea));
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  // full hard reset, then wait for the lock with a bound
  task automatic detect(input logic [5:0] s, input logic [7:0] d, input hiad_if_t e);
    int i;
    strap_sel = s;
    data_sel = d;
    rst = 1'h1;
    step(16);
    rst = 1'h0;
    for (i = 0; i < 80 && locked !== 1'h1; i++) step(1);
    chk({7'h00, locked}, 8'h01);
    chk({5'h00, if_type}, {5'h00, e});
  endtask
  task automatic t_table;
    detect(6'h00, 8'h00, HIAD_IF_UART);
    detect(6'h01, 8'h00, HIAD_IF_SPI);
    detect(6'h02, 8'h00, HIAD_IF_I2C);
    detect(6'h07, 8'h00, HIAD_IF_PAR_SEP);
    detect(6'h06, 8'h00, HIAD_IF_PAR_COM);
    detect(6'h2A, 8'h00, HIAD_IF_PAR_DED);
  endtask
  // address pins give bit0=d6, bit1=d5, bits2..6=d4..d0
  task automatic t_i2c;
    detect(6'h03, 8'h5A, HIAD_IF_I2C);
    chk({1'h0, i2c_addr}, 8'h2D);
    chk({7'h00, ea}, 8'h01);
    chk({6'h00, sda, scl}, 8'h02);
    detect(6'h02, 8'h5A, HIAD_IF_I2C);
    chk({1'h0, i2c_addr}, 8'h2C);
    chk({7'h00, ea}, 8'h00);
    chk(d_oe, 8'h00);
    strap_sel = 6'h01;
    latch_sel = 1'h0;
    step(20);
    chk({5'h00, if_type}, {5'h00, HIAD_IF_I2C});
    chk({7'h00, sda}, 8'h00);
    latch_sel = 1'h1;
  endtask
  task automatic t_route;
    detect(6'h01, 8'hC0, HIAD_IF_SPI);
    chk({6'h00, mosi, sck}, 8'h02);
    latch_sel = 1'h0;
    miso_en = 1'h1;
    miso_d = 1'h1;
    step(6);
    chk({6'h00, nss, d_oe[7]}, 8'h01);
    chk({7'h00, d_o[7]}, 8'h01);
    latch_sel = 1'h1;
    detect(6'h00, 8'h00, HIAD_IF_UART);
    latch_sel = 1'h0;
    tx_d = 1'h0;
    aux_d = 1'h1;
    req_d = 1'h1;
    step(6);
    chk({6'h00, rx, d_o[7]}, 8'h00);
    chk(d_o, 8'h60);
    chk(d_oe, 8'hE0);
    chk({3'h0, d_oe[4:0]}, 8'h00);
    latch_sel = 1'h1;
  endtask
  task automatic summarize;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // whole run is about 10 resets of some 60 cycles
  initial begin
    #(25 * 5000);
    n_errors++;
    summarize();
  end
  initial begin
    t_table();
    t_i2c();
    t_route();
    summarize();
  end
endmodule
